// File: dhi_defines.vh
// constants shared by the digital input handler files
`ifndef DHI_DEFINES_VH
`define DHI_DEFINES_VH

// timing: sample period and clock period in ns
`define DHI_CLK_PERIOD_NS 25
`define DHI_SAMPLE_PERIOD_NS 2000000
`define DHI_NUM_INPUTS 8

// register word indices (byte address is four times the index)
`define DHI_ADR_CTRL 6'h00
`define DHI_ADR_STANDBY 6'h01
`define DHI_ADR_POSTBRK 6'h02
`define DHI_ADR_RAMP 6'h03
`define DHI_ADR_STATUS 6'h04
`define DHI_CFG_BLOCK 3'h1

// control register fields
`define DHI_CTRL_EN 0
`define DHI_CTRL_BC 1
`define DHI_CTRL_BFC 2
`define DHI_CTRL_SM_LO 8
`define DHI_CTRL_SM_HI 15
`define DHI_SM_STAY_BIT 1
`define DHI_CTRL_RST 32'h0000_0006

// per input configuration fields
`define DHI_CFG_H_HI 7
`define DHI_CFG_DB_LO 8
`define DHI_CFG_DB_HI 15
`define DHI_CFG_INV 16
`define DHI_CFG_LVL 17
`define DHI_HND_RST 8'h00
`define DHI_DB_RST 8'h01

// status register fields
`define DHI_ST_ERR 16
`define DHI_ST_EN 17
`define DHI_ST_BRK 18
`define DHI_ST_SEQ_LO 20

// handler function codes
`define DHI_H_NULL 8'h00
`define DHI_H_BRAKE 3
`define DHI_H_POS 6
`define DHI_H_NEG 7
`define DHI_H_HOME 8
`define DHI_H_QSTOP 9
`define DHI_H_AUTO 10
`define DHI_H_CDIS 11
`define DHI_H_CANED 17
`define DHI_H_CANRE 18
`define DHI_H_BOOT 19
`define DHI_FSTATE_RST 32'h0000_00c0

// control loop modes
`define DHI_MODE_TORQUE 2'h0
`define DHI_MODE_VEL 2'h1

`endif

// File: dhi_debounce.v
// one front panel input: pin synchroniser and sample debounce
`timescale 1ns/1ps
module dhi_debounce (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // sample tick and debounce count
   input wire tick_i,
   input wire [7:0] count_i,
   // pin
   input wire pin_i,
   // results
   output reg raw_o,
   output reg level_o,
   output reg change_o
);
   reg s1_q, s2_q, s3_q;
   reg cand_q;
   reg [7:0] run_q;
   wire [7:0] need_w;
   wire [7:0] nrun_w;

   // a count of zero behaves as one sample
   assign need_w = (count_i == 8'h00) ? 8'h01 : count_i;
   // run saturates instead of wrapping back to a short count
   assign nrun_w = (raw_o != cand_q) ? 8'h01 :
                   ((run_q == 8'hff) ? run_q : run_q + 8'h01);

   // three stage synchroniser, raw level moves when stages two and three agree
   always @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         raw_o <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            raw_o <= s3_q;
         end
      end
   end

   // a differing sample restarts the run at one
   always @(posedge clk_i) begin
      if (rst_i) begin
         cand_q <= 1'b0;
         run_q <= 8'h00;
         level_o <= 1'b0;
         change_o <= 1'b0;
      end else begin
         change_o <= 1'b0;
         if (tick_i) begin
            cand_q <= raw_o;
            run_q <= nrun_w;
            if (nrun_w >= need_w && level_o != raw_o) begin
               level_o <= raw_o;
               change_o <= 1'b1;
            end
         end
      end
   end
endmodule // dhi_debounce

// File: dhi_input_handler.v
// digital input handler: debounce, handler dispatch, limit and brake control
`timescale 1ns/1ps
`include "dhi_defines.vh"
module dhi_input_handler #(
   parameter TICK_CYCLES = `DHI_SAMPLE_PERIOD_NS / `DHI_CLK_PERIOD_NS,
   parameter TICK_W = 17
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // front panel pins, first input in bit 0
   input wire [7:0] din_i,
   // motion control status
   input wire homing_i,
   input wire fault_i,
   input wire [15:0] speed_i,
   input wire [1:0] ctl_mode_i,
   // drive and brake control
   output reg drive_en_o,
   output reg brake_release_o,
   output reg pos_block_o,
   output reg neg_block_o,
   output reg torque_zero_o,
   output reg decel_o,
   output reg quickstop_o,
   // other handler results
   output reg homing_sw_o,
   output reg auto_mode_o,
   output reg can_off_o,
   output reg reboot_o,
   output reg [7:0] handler_call_o
);
   localparam SEQ_IDLE = 2'h0;
   localparam SEQ_DECEL = 2'h1;
   localparam SEQ_BRAKE = 2'h2;
   localparam SEQ_OFF = 2'h3;
   localparam N = `DHI_NUM_INPUTS;
   localparam [31:0] CTRL_RST = `DHI_CTRL_RST;

   // byte lane merge of a write into a register value
   function [31:0] wmerge;
      input [31:0] cur;
      input [31:0] wd;
      input [3:0] sel;
      integer b;
      begin
         wmerge = cur;
         for (b = 0; b < 4; b = b + 1) begin
            if (sel[b]) begin
               wmerge[b*8 +: 8] = wd[b*8 +: 8];
            end
         end
      end
   endfunction

   reg [TICK_W-1:0] div_q;
   reg tick_q, tick_d_q, pow_q;
   reg en_req_q, bc_q, bfc_q;
   reg [7:0] smode_q;
   reg [15:0] standby_q, post_brake_off_delay_q, ramp_lim_q;
   reg [7:0] hnd_q [0:N-1];
   reg [7:0] dbc_q [0:N-1];
   reg [7:0] inv_q, lvlm_q, first_q, invchg_q;
   reg map_err_q;
   reg [31:0] fstate_q;
   reg lim_prev_q, cdis_prev_q;
   reg [1:0] seq_q;
   reg [15:0] seq_cnt_q;
   wire [7:0] raw_w, lvl_w, chg_w, eff_w;
   reg [7:0] call_w;
   reg [31:0] fhit_w, fval_w, fasg_w;
   reg dup_w;
   reg [31:0] rd_w;
   integer i;

   // bus decode: one cycle answer, unmapped words read zero
   wire req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr_w = req_w & wb_we_i;
   wire [5:0] widx_w = wb_adr_i[7:2];
   wire cfg_hit_w = (widx_w[5:3] == `DHI_CFG_BLOCK);
   wire [2:0] cfg_k_w = widx_w[2:0];
   wire [31:0] ctrl_w = {16'h0000, smode_q, 5'h00, bfc_q, bc_q, en_req_q};
   wire [31:0] cfg_cur_w = {14'h0000, lvlm_q[cfg_k_w], inv_q[cfg_k_w],
                            dbc_q[cfg_k_w], hnd_q[cfg_k_w]};
   wire [31:0] cfg_new_w = wmerge(cfg_cur_w, wb_dat_i, wb_sel_i);
   wire [7:0] new_h_w = cfg_new_w[`DHI_CFG_H_HI:0];
   wire cfg_wr_w = wr_w & cfg_hit_w;
   // merged write values, cut to the field widths below
   wire [31:0] ctrl_new_w = wmerge(ctrl_w, wb_dat_i, wb_sel_i);
   wire [31:0] stby_new_w = wmerge({16'h0000, standby_q}, wb_dat_i, wb_sel_i);
   wire [31:0] pbd_new_w = wmerge({16'h0000, post_brake_off_delay_q},
                                  wb_dat_i, wb_sel_i);
   wire [31:0] ramp_new_w = wmerge({16'h0000, ramp_lim_q}, wb_dat_i, wb_sel_i);

   // 2 ms sample tick; count is a parameter so a bench can shorten it
   always @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= {TICK_W{1'b0}};
         tick_q <= 1'b0;
         tick_d_q <= 1'b0;
      end else begin
         tick_d_q <= tick_q;
         if (div_q == TICK_CYCLES[TICK_W-1:0] - 1'b1) begin
            div_q <= {TICK_W{1'b0}};
            tick_q <= 1'b1;
         end else begin
            div_q <= div_q + 1'b1;
            tick_q <= 1'b0;
         end
      end
   end

   // one debouncer per input, all eight share the tick
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_in
         dhi_debounce u_deb (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tick_i(tick_q),
            .count_i(dbc_q[g]),
            .pin_i(din_i[g]),
            .raw_o(raw_w[g]),
            .level_o(lvl_w[g]),
            .change_o(chg_w[g])
         );
      end
   endgenerate

   assign eff_w = lvl_w ^ inv_q;

   // a non-null handler already on another input refuses the handler field of the write
   always @* begin
      dup_w = 1'b0;
      for (i = 0; i < N; i = i + 1) begin
         if (i[2:0] != cfg_k_w && hnd_q[i] == new_h_w &&
             new_h_w != `DHI_H_NULL) begin
            dup_w = 1'b1;
         end
      end
   end

   // register writes
   always @(posedge clk_i) begin
      if (rst_i) begin
         en_req_q <= CTRL_RST[`DHI_CTRL_EN];
         bc_q <= CTRL_RST[`DHI_CTRL_BC];
         bfc_q <= CTRL_RST[`DHI_CTRL_BFC];
         smode_q <= CTRL_RST[`DHI_CTRL_SM_HI:`DHI_CTRL_SM_LO];
         standby_q <= 16'h0000;
         post_brake_off_delay_q <= 16'h0000;
         ramp_lim_q <= 16'h0000;
         inv_q <= 8'h00;
         lvlm_q <= 8'h00;
         first_q <= 8'h00;
         invchg_q <= 8'h00;
         map_err_q <= 1'b0;
         for (i = 0; i < N; i = i + 1) begin
            hnd_q[i] <= `DHI_HND_RST;
            dbc_q[i] <= `DHI_DB_RST;
         end
      end else begin
         first_q <= 8'h00;
         invchg_q <= 8'h00;
         if (wr_w && widx_w == `DHI_ADR_CTRL) begin
            en_req_q <= ctrl_new_w[`DHI_CTRL_EN];
            bc_q <= ctrl_new_w[`DHI_CTRL_BC];
            bfc_q <= ctrl_new_w[`DHI_CTRL_BFC];
            smode_q <= ctrl_new_w[`DHI_CTRL_SM_HI:`DHI_CTRL_SM_LO];
         end
         if (wr_w && widx_w == `DHI_ADR_STANDBY) begin
            standby_q <= stby_new_w[15:0];
         end
         if (wr_w && widx_w == `DHI_ADR_POSTBRK) begin
            post_brake_off_delay_q <= pbd_new_w[15:0];
         end
         if (wr_w && widx_w == `DHI_ADR_RAMP) begin
            ramp_lim_q <= ramp_new_w[15:0];
         end
         if (cfg_wr_w) begin
            if (!dup_w) begin
               hnd_q[cfg_k_w] <= new_h_w;
               // reassigning a live input does not call the new handler
               first_q[cfg_k_w] <= (hnd_q[cfg_k_w] == `DHI_H_NULL) &&
                                   (new_h_w != `DHI_H_NULL);
            end
            dbc_q[cfg_k_w] <= cfg_new_w[`DHI_CFG_DB_HI:`DHI_CFG_DB_LO];
            inv_q[cfg_k_w] <= cfg_new_w[`DHI_CFG_INV];
            lvlm_q[cfg_k_w] <= cfg_new_w[`DHI_CFG_LVL];
            invchg_q[cfg_k_w] <= cfg_new_w[`DHI_CFG_INV] ^ inv_q[cfg_k_w];
         end
         // a new refused write wins over a clear in the same cycle
         if (cfg_wr_w && dup_w) begin
            map_err_q <= 1'b1;
         end else if (wr_w && widx_w == `DHI_ADR_STATUS &&
                      wb_sel_i[`DHI_ST_ERR/8] && wb_dat_i[`DHI_ST_ERR]) begin
            map_err_q <= 1'b0;
         end
      end
   end

   // handler calls and dispatch by handler code
   always @* begin
      fhit_w = 32'h0000_0000;
      fval_w = 32'h0000_0000;
      fasg_w = 32'h0000_0000;
      for (i = 0; i < N; i = i + 1) begin
         call_w[i] = (hnd_q[i] != `DHI_H_NULL) &&
            (first_q[i] || invchg_q[i] || (pow_q && tick_d_q) ||
             (lvlm_q[i] ? tick_d_q : chg_w[i]));
         if (hnd_q[i][7:5] == 3'h0) begin
            fasg_w[hnd_q[i][4:0]] = 1'b1;
            if (call_w[i]) begin
               fhit_w[hnd_q[i][4:0]] = 1'b1;
               fval_w[hnd_q[i][4:0]] = eff_w[i];
            end
         end
      end
   end

   // handler state only moves when its handler is called
   always @(posedge clk_i) begin
      if (rst_i) begin
         pow_q <= 1'b1;
         fstate_q <= `DHI_FSTATE_RST;
         can_off_o <= 1'b0;
         reboot_o <= 1'b0;
         handler_call_o <= 8'h00;
      end else begin
         if (tick_d_q) begin
            pow_q <= 1'b0;
         end
         fstate_q <= (fstate_q & ~fhit_w) | (fval_w & fhit_w);
         handler_call_o <= call_w;
         reboot_o <= fhit_w[`DHI_H_BOOT] & fval_w[`DHI_H_BOOT];
         if (fhit_w[`DHI_H_CANED]) begin
            can_off_o <= fval_w[`DHI_H_CANED];
         end else if (fhit_w[`DHI_H_CANRE] && fval_w[`DHI_H_CANRE]) begin
            can_off_o <= 1'b0;
         end
      end
   end

   // limits are active while their input reads cleared
   wire pos_act_w = fasg_w[`DHI_H_POS] & ~fstate_q[`DHI_H_POS];
   wire neg_act_w = fasg_w[`DHI_H_NEG] & ~fstate_q[`DHI_H_NEG];
   wire lim_w = pos_act_w | neg_act_w;
   wire cdis_w = fasg_w[`DHI_H_CDIS] & fstate_q[`DHI_H_CDIS];
   wire brk_asg_w = fasg_w[`DHI_H_BRAKE];
   wire brk_in_w = fstate_q[`DHI_H_BRAKE];
   wire stop_start_w = (lim_w & ~lim_prev_q & ~homing_i &
                        ~smode_q[`DHI_SM_STAY_BIT]) |
                       (cdis_w & ~cdis_prev_q);
   wire drive_en_w = en_req_q & lvl_w[0] & (seq_q != SEQ_OFF);
   wire seq_brk_w = (seq_q == SEQ_BRAKE) | (seq_q == SEQ_OFF);

   // stop with disable: ramp down, brake, then disable
   always @(posedge clk_i) begin
      if (rst_i) begin
         seq_q <= SEQ_IDLE;
         seq_cnt_q <= 16'h0000;
         lim_prev_q <= 1'b0;
         cdis_prev_q <= 1'b0;
      end else begin
         lim_prev_q <= lim_w;
         cdis_prev_q <= cdis_w;
         case (seq_q)
            SEQ_IDLE: begin
               seq_cnt_q <= 16'h0000;
               if (stop_start_w && drive_en_o) begin
                  seq_q <= SEQ_DECEL;
               end
            end
            SEQ_DECEL: begin
               if (speed_i < standby_q) begin
                  seq_q <= SEQ_BRAKE;
                  seq_cnt_q <= 16'h0000;
               end else if (seq_cnt_q >= ramp_lim_q) begin
                  seq_q <= SEQ_OFF;
               end else if (tick_q) begin
                  seq_cnt_q <= seq_cnt_q + 16'h0001;
               end
            end
            SEQ_BRAKE: begin
               if (seq_cnt_q >= post_brake_off_delay_q) begin
                  seq_q <= SEQ_OFF;
               end else if (tick_q) begin
                  seq_cnt_q <= seq_cnt_q + 16'h0001;
               end
            end
            SEQ_OFF: begin
               // held off until software or the enable input drops enable
               if (!en_req_q || !lvl_w[0]) begin
                  seq_q <= SEQ_IDLE;
               end
            end
            default: begin
               seq_q <= SEQ_IDLE;
            end
         endcase
      end
   end

   // output stage, every output straight from a flop
   always @(posedge clk_i) begin
      if (rst_i) begin
         drive_en_o <= 1'b0;
         brake_release_o <= 1'b0;
         pos_block_o <= 1'b0;
         neg_block_o <= 1'b0;
         torque_zero_o <= 1'b0;
         decel_o <= 1'b0;
         quickstop_o <= 1'b0;
         homing_sw_o <= 1'b0;
         auto_mode_o <= 1'b0;
      end else begin
         drive_en_o <= drive_en_w;
         if (fault_i) begin
            // fault authority at zero leaves the brake to the input
            brake_release_o <= (bfc_q | ~brk_asg_w) ? 1'b0 :
                               brk_in_w;
         end else begin
            brake_release_o <= (bc_q | ~brk_asg_w) ?
                               (drive_en_w & ~seq_brk_w) :
                               brk_in_w;
         end
         // homing keeps its own moves, so no direction block then
         pos_block_o <= pos_act_w & ~homing_i;
         neg_block_o <= neg_act_w & ~homing_i;
         torque_zero_o <= lim_w & ~homing_i &
                          (ctl_mode_i == `DHI_MODE_TORQUE);
         decel_o <= lim_w & ~homing_i &
                    (ctl_mode_i == `DHI_MODE_VEL);
         quickstop_o <= (fasg_w[`DHI_H_QSTOP] & fstate_q[`DHI_H_QSTOP]) |
                        (lim_w & homing_i) | (seq_q == SEQ_DECEL);
         homing_sw_o <= fasg_w[`DHI_H_HOME] & fstate_q[`DHI_H_HOME];
         auto_mode_o <= fasg_w[`DHI_H_AUTO] & fstate_q[`DHI_H_AUTO];
      end
   end

   // read mux
   always @* begin
      rd_w = 32'h0000_0000;
      if (cfg_hit_w) begin
         rd_w = cfg_cur_w;
      end else begin
         case (widx_w)
            `DHI_ADR_CTRL: rd_w = ctrl_w;
            `DHI_ADR_STANDBY: rd_w = {16'h0000, standby_q};
            `DHI_ADR_POSTBRK: rd_w = {16'h0000, post_brake_off_delay_q};
            `DHI_ADR_RAMP: rd_w = {16'h0000, ramp_lim_q};
            `DHI_ADR_STATUS: rd_w = {10'h000, seq_q, 1'b0, brake_release_o,
               drive_en_o, map_err_q, eff_w, raw_w};
            default: rd_w = 32'h0000_0000;
         endcase
      end
   end

   // bus answer one cycle after the request, dropped the next cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req_w;
         if (req_w && !wb_we_i) begin
            wb_dat_o <= rd_w;
         end
      end
   end
endmodule // dhi_input_handler

// File: dhi_input_handler_properties.sv
// checker: port level properties of the digital input handler
`timescale 1ns/1ps
`include "dhi_defines.vh"
module dhi_input_handler_properties (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // bus handshake
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   // pins and motion status
   input wire [7:0] din_i,
   input wire homing_i,
   input wire [1:0] ctl_mode_i,
   // drive control
   input wire drive_en_o,
   input wire brake_release_o,
   input wire pos_block_o,
   input wire neg_block_o,
   input wire torque_zero_o,
   input wire decel_o,
   input wire quickstop_o
);
   reg [5:0] lo_q;
   reg [5:0] hi_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // run lengths of the enable pin, saturating so long runs stay counted
   always @(posedge clk_i) begin
      if (rst_i) begin
         lo_q <= 6'h00;
         hi_q <= 6'h00;
      end else begin
         lo_q <= din_i[0] ? 6'h00 : lo_q + {5'h00, lo_q != 6'h3f};
         hi_q <= !din_i[0] ? 6'h00 : hi_q + {5'h00, hi_q != 6'h3f};
      end
   end
   a_ack_one_pulse:
      assert property (wb_ack_o |=> !wb_ack_o)
         else $error("ack held longer than one cycle");
   a_ack_in_one:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
         else $error("request not answered in one cycle");
   a_ack_needs_req:
      assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
         else $error("ack without a request");
   // 40 cycles covers sync, one sample period and the output flop
   a_en_low_pin:
      assert property (lo_q >= 6'h28 |-> !drive_en_o)
         else $error("drive enabled with enable pin low");
   a_en_rise_pin:
      assert property ($rose(drive_en_o) |-> hi_q >= 6'h04)
         else $error("drive enabled before enable pin settled high");
   a_block_homing:
      assert property (homing_i |=> !pos_block_o && !neg_block_o)
         else $error("limit block active during homing");
   a_torque_mode:
      assert property (ctl_mode_i != `DHI_MODE_TORQUE |=> !torque_zero_o)
         else $error("torque zeroed outside torque mode");
   a_decel_mode:
      assert property (ctl_mode_i != `DHI_MODE_VEL |=> !decel_o)
         else $error("decel outside velocity mode");
   a_stop_has_block:
      assert property (torque_zero_o || decel_o |-> pos_block_o || neg_block_o)
         else $error("limit stop without a direction block");
   cover property ($rose(drive_en_o));
   cover property (pos_block_o && torque_zero_o);
   cover property (homing_i && quickstop_o);
   cover property ($fell(brake_release_o) && drive_en_o);
endmodule // dhi_input_handler_properties

// File: dhi_drive_model.sv
// motor model on the far side: speed seen by the stop sequencer
`timescale 1ns/1ps
module dhi_drive_model (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // drive command
   input wire drive_en_i,
   input wire stop_i,
   // feedback
   output reg [15:0] speed_o
);
   // coasts down one step a cycle, slow enough to see the decel phase
   always @(posedge clk_i) begin
      if (rst_i)
         speed_o <= 16'h0000;
      else if (drive_en_i && !stop_i)
         speed_o <= 16'h0064;
      else if (speed_o != 16'h0000)
         speed_o <= speed_o - 16'h0001;
   end
endmodule // dhi_drive_model

// File: testbench.sv
// testbench for the digital input handler
`timescale 1ns/1ps
`include "dhi_defines.vh"
module testbench;
   reg clk_i = 0;
   reg rst_i = 1;
   reg cyc = 0, stb = 0, we = 0, homing = 0, fault = 0;
   reg [7:0] adr = 0, din = 0;
   reg [3:0] sel = 0;
   reg [1:0] mode = 0;
   reg [31:0] wdat = 0, q;
   wire [31:0] rdat;
   wire [15:0] speed;
   wire [7:0] call;
   wire ack, en, brk, pblk, nblk, tz, dec, qs;
   integer mismatches = 0, checked = 0, wn;
   always #12.5 clk_i = ~clk_i;
   dhi_input_handler #(.TICK_CYCLES(8), .TICK_W(17)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .din_i(din), .homing_i(homing),
      .fault_i(fault), .speed_i(speed), .ctl_mode_i(mode),
      .drive_en_o(en), .brake_release_o(brk), .pos_block_o(pblk),
      .neg_block_o(nblk), .torque_zero_o(tz), .decel_o(dec),
      .quickstop_o(qs), .homing_sw_o(), .auto_mode_o(), .can_off_o(),
      .reboot_o(), .handler_call_o(call));
   dhi_drive_model model_u (.clk_i(clk_i), .rst_i(rst_i), .drive_en_i(en),
      .stop_i(qs | dec | tz), .speed_o(speed));
   task conclude;
      begin
         $display("checked=%0d mismatches=%0d", checked, mismatches);
         if (mismatches == 0 && checked > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // one classic cycle; q takes read data at the ack edge
   task bus(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clk_i);
         cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'hf; wdat <= d;
         n = 0;
         @(posedge clk_i);
         while (ack !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n = n + 1;
         end
         q = rdat;
         cyc <= 0; stb <= 0; we <= 0;
         if (n == 50) begin
            chk(32'h0000_0000, 32'h0000_0001);
            conclude;
         end
      end
   endtask
   function pick(input [2:0] s);
      case (s)
         0: pick = en;
         1: pick = brk;
         2: pick = pblk;
         3: pick = qs;
         4: pick = tz;
         default: pick = dec;
      endcase
   endfunction
   // bounded wait for an output level; wn keeps the cycles spent
   task wt(input [2:0] s, input v);
      begin
         wn = 0;
         while (pick(s) !== v && wn < 3000) begin
            @(posedge clk_i);
            wn = wn + 1;
         end
         chk({31'h0, pick(s)}, {31'h0, v});
         if (wn == 3000) conclude;
      end
   endtask
   task wcall(input [7:0] m);
      begin
         wn = 0;
         while ((call & m) === 8'h00 && wn < 40) begin
            @(posedge clk_i);
            wn = wn + 1;
         end
         chk({24'h0, call & m}, {24'h0, m});
         if (wn == 40) conclude;
      end
   endtask
   task t_regs;
      begin
         bus(0, 8'h00, 0); chk(q, `DHI_CTRL_RST);
         bus(0, 8'h18, 0); chk(q, 32'h0000_0000);
         bus(0, 8'h24, 0); chk(q, 32'h0000_0100);
         bus(1, 8'h04, 32'h0000_000a);
         bus(0, 8'h04, 0); chk(q, 32'h0000_000a);
         bus(1, 8'h08, 32'h0000_0002);
         bus(1, 8'h0c, 32'h0000_00ff);
         $display("test regs done");
      end
   endtask
   task t_status;
      begin
         @(posedge clk_i) din <= 8'ha7;
         bus(1, 8'h28, 32'h0001_0100);
         repeat (8) @(posedge clk_i);
         bus(0, 8'h10, 0); chk(q & 32'h0000_00ff, 32'h0000_00a7);
         $display("test status done");
      end
   endtask
   task t_enable;
      begin
         bus(1, 8'h20, 32'h0000_010a);
         bus(1, 8'h00, 32'h0000_0007);
         wt(0, 1);
         chk({31'h0, dut_u.auto_mode_o}, 1);
         wt(1, 1);
         @(posedge clk_i) din[0] <= 1'b0;
         wt(0, 0);
         wt(1, 0);
         @(posedge clk_i) din[0] <= 1'b1;
         wt(0, 1);
         $display("test enable done");
      end
   endtask
   // pins stay still while handlers are remapped
   task t_dup;
      begin
         bus(1, 8'h24, 32'h0000_0106); wcall(8'h02);
         bus(1, 8'h28, 32'h0000_0106);
         bus(0, 8'h10, 0); chk(q & 32'h0001_0000, 32'h0001_0000);
         bus(0, 8'h28, 0); chk(q & 32'h0000_00ff, 32'h0000_0000);
         bus(1, 8'h10, 32'h0001_0000);
         bus(1, 8'h2c, 32'h0000_0100);
         bus(1, 8'h30, 32'h0000_0100);
         bus(0, 8'h10, 0); chk(q & 32'h0001_0000, 32'h0000_0000);
         bus(1, 8'h2c, 32'h0002_0108); wcall(8'h08);
         repeat (3) @(posedge clk_i);
         wcall(8'h08);
         $display("test mapping done");
      end
   endtask
   task t_limit;
      begin
         bus(1, 8'h00, 32'h0000_0207);
         bus(1, 8'h24, 32'h0000_0406);
         @(posedge clk_i) din[1] <= 1'b0;
         wt(2, 1);
         chk(wn >= 24, 1);
         wt(4, 1);
         chk({31'h0, en}, 1);
         @(posedge clk_i) homing <= 1'b1;
         wt(2, 0);
         wt(3, 1);
         @(posedge clk_i) begin
            homing <= 1'b0;
            din[1] <= 1'b1;
         end
         repeat (60) @(posedge clk_i);
         chk({31'h0, pblk}, 0);
         chk({31'h0, nblk}, 0);
         bus(1, 8'h00, 32'h0000_0007);
         @(posedge clk_i) begin
            mode <= `DHI_MODE_VEL;
            din[1] <= 1'b0;
         end
         wt(5, 1);
         wt(1, 0);
         chk({31'h0, en}, 1);
         wt(0, 0);
         $display("test limit done");
      end
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      t_regs;
      t_status;
      t_enable;
      t_dup;
      t_limit;
      conclude;
   end
endmodule // testbench
bind dhi_input_handler dhi_input_handler_properties chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .din_i(din_i), .homing_i(homing_i),
   .ctl_mode_i(ctl_mode_i), .drive_en_o(drive_en_o),
   .brake_release_o(brake_release_o), .pos_block_o(pos_block_o),
   .neg_block_o(neg_block_o), .torque_zero_o(torque_zero_o),
   .decel_o(decel_o), .quickstop_o(quickstop_o));
